/* brc_pkg.sv */
// How it works
// - Each converter switches at 1.125MHz or 2.25MHz, chosen by a select bit.
// - Default mode is PWM, power-save at light load without reverse current.
// - Low-quiescent mode only when low-power disable is 0 and select is 1.
// - Force bit set keeps converters in PWM even at light load.
// - At full duty the high-side switch stays on continuously; the code holds it only in the run state, not during soft-start.
// - Soft-start ramp runs at every enable and every restart after a fault.
// - One shared bit picks ramp length: 600us when 0, 250us when 1.
// - Regulate to primary code normally, alternate code in voltage scaling mode.
// - Setpoint codes are unsigned 8-bit values scaling the regulator step.
// - Buck1 target is 0.6V plus code times 9.376mV.
// - Buck2 and Buck3 targets are 0.8V plus code times 12.5mV.
// - Force bit is set to 1 during any setpoint transition.
// - Target code slews one LSB at a time while running; when off or in soft-start it follows the setpoint directly.
// - Primary must exceed alternate; otherwise flag overvoltage during scaling.
// - Software on bit enables or disables each converter.
// - Disabling a trigger converter disables followers only if the link register links them.
// - Disabled converters connect output discharge: 4.4 ohm Buck1, 9.4 ohm others.
package brc_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int SS_SLOW_US = 600;
  localparam int SS_FAST_US = 250;
  localparam int SS_SLOW_CYC = (SS_SLOW_US * (CLK_HZ / 1000)) / 1000;
  localparam int SS_FAST_CYC = (SS_FAST_US * (CLK_HZ / 1000)) / 1000;
  // Buck1 offset 600mV, step 9.376mV; Buck2/3 offset 800mV, step 12.5mV, in microvolts.
  localparam int B1_OFFSET_UV = 600000;
  localparam int B1_STEP_UV = 9376;
  localparam int B23_OFFSET_UV = 800000;
  localparam int B23_STEP_UV = 12500;
  localparam int SLEW_CYC = 25;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ON = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam logic [3:0] ADDR_LINK = 4'h4;
  localparam logic [3:0] ADDR_STATE = 4'h5;
  localparam logic [3:0] ADDR_PRI0 = 4'h8;
  localparam logic [3:0] ADDR_ALT0 = 4'hc;
  localparam logic [3:0] ADDR_CODE0 = 4'h6;
  // Control register fields.
  localparam int CTRL_FAST_SS = 0;
  localparam int CTRL_FORCE = 1;
  localparam int CTRL_LP_DIS = 2;
  localparam int CTRL_LP_SEL = 3;
  localparam int CTRL_SCALE = 4;
  localparam int CTRL_FSW = 5;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] CODE_RST = 8'h00;
  typedef enum logic [1:0] {
    BRC_MODE_PWM = 2'b00,
    BRC_MODE_SAVE = 2'b01,
    BRC_MODE_LPQ = 2'b10
  } brc_mode_t;
  typedef enum logic [1:0] {
    BRC_OFF = 2'b00,
    BRC_RAMP = 2'b01,
    BRC_RUN = 2'b10
  } brc_state_t;
endpackage

/* brc_top.sv */
`timescale 1ns/100ps
module brc_top #(
  parameter int NUM_BUCK = 3,
  parameter int SS_SLOW_CYCLES = brc_pkg::SS_SLOW_CYC,
  parameter int SS_FAST_CYCLES = brc_pkg::SS_FAST_CYC,
  parameter int SLEW_CYCLES = brc_pkg::SLEW_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [NUM_BUCK-1:0] fault_restart,
  input wire logic [NUM_BUCK-1:0] light_load,
  input wire logic [NUM_BUCK-1:0] full_duty,
  output logic [NUM_BUCK*8-1:0] output_voltage_code,
  output logic [NUM_BUCK*2-1:0] buck_mode,
  output logic [NUM_BUCK-1:0] soft_start_active,
  output logic [NUM_BUCK-1:0] high_side_hold,
  output logic [NUM_BUCK-1:0] discharge_en,
  output logic [NUM_BUCK-1:0] buck_enabled,
  output logic fsw_high_select,
  output logic irq
);
  localparam int CW = 16;
  // Counts must fit the 16-bit counters, and the status and link maps hold three bucks.
  if (NUM_BUCK < 1 || NUM_BUCK > 3) begin : g_bad_num
    $error("NUM_BUCK must be 1 to 3.");
  end
  if (SS_SLOW_CYCLES < 1 || SS_SLOW_CYCLES >= 2**CW) begin : g_bad_slow
    $error("Slow soft-start count out of range.");
  end
  if (SS_FAST_CYCLES < 1 || SS_FAST_CYCLES >= 2**CW) begin : g_bad_fast
    $error("Fast soft-start count out of range.");
  end
  if (SLEW_CYCLES < 1 || SLEW_CYCLES >= 2**CW) begin : g_bad_slew
    $error("Slew count out of range.");
  end

  logic [7:0] ctrl_r;
  logic [NUM_BUCK-1:0] on_r;
  logic [NUM_BUCK-1:0] link_r;
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] pri_r [NUM_BUCK];
  logic [7:0] alt_r [NUM_BUCK];
  logic [7:0] code_r [NUM_BUCK];
  logic [CW-1:0] ss_cnt_r [NUM_BUCK];
  logic [CW-1:0] slew_cnt_r [NUM_BUCK];
  brc_pkg::brc_state_t st_r [NUM_BUCK];
  logic [NUM_BUCK-1:0] moving;
  logic [NUM_BUCK-1:0] ov_evt;
  logic [NUM_BUCK-1:0] run_en;
  logic force_saved_r;
  logic in_trans_r;
  logic any_moving;
  logic force_eff;
  logic lpq_ok;
  logic [7:0] status_set;
  logic [7:0] rdata_nxt;

  function automatic logic [7:0] target_code(input logic scale, input logic [7:0] p,
                                             input logic [7:0] a);
    target_code = scale ? a : p;
  endfunction

  assign any_moving = |moving;
  assign force_eff = ctrl_r[brc_pkg::CTRL_FORCE];
  assign lpq_ok = !ctrl_r[brc_pkg::CTRL_LP_DIS] && ctrl_r[brc_pkg::CTRL_LP_SEL];
  assign fsw_high_select = ctrl_r[brc_pkg::CTRL_FSW];

  // A buck is on if its own bit is set and, when linked, its predecessor is enabled.
  always_comb begin
    for (int i = 0; i < NUM_BUCK; i++) begin
      if (i > 0 && link_r[i]) begin
        run_en[i] = on_r[i] && run_en[i-1];
      end else begin
        run_en[i] = on_r[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= brc_pkg::CTRL_RST;
      on_r <= '0;
      link_r <= '0;
      mask_r <= 8'h00;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        brc_pkg::ADDR_CTRL: ctrl_r <= reg_wdata;
        brc_pkg::ADDR_ON: on_r <= reg_wdata[NUM_BUCK-1:0];
        brc_pkg::ADDR_MASK: mask_r <= reg_wdata;
        brc_pkg::ADDR_LINK: link_r <= reg_wdata[NUM_BUCK-1:0];
        default: ;
      endcase
    end else if (clk_en && !in_trans_r && any_moving) begin
      ctrl_r[brc_pkg::CTRL_FORCE] <= 1'b1;
    end else if (clk_en && in_trans_r && !any_moving) begin
      ctrl_r[brc_pkg::CTRL_FORCE] <= force_saved_r;
    end
  end

  // The saved force value is captured on the first moving cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_trans_r <= 1'b0;
      force_saved_r <= 1'b0;
    end else if (clk_en) begin
      in_trans_r <= any_moving;
      if (!in_trans_r && any_moving) begin
        force_saved_r <= ctrl_r[brc_pkg::CTRL_FORCE];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_BUCK; g++) begin : g_buck
      logic [7:0] tgt;
      logic [CW-1:0] ss_len;
      assign tgt = target_code(ctrl_r[brc_pkg::CTRL_SCALE], pri_r[g], alt_r[g]);
      assign ss_len = ctrl_r[brc_pkg::CTRL_FAST_SS] ? CW'(SS_FAST_CYCLES)
                                                    : CW'(SS_SLOW_CYCLES);
      assign moving[g] = (st_r[g] == brc_pkg::BRC_RUN) && (code_r[g] != tgt);
      // Overvoltage is flagged when scaling runs with the primary not above the alternate.
      assign ov_evt[g] = ctrl_r[brc_pkg::CTRL_SCALE] && (pri_r[g] <= alt_r[g]) &&
                         (st_r[g] != brc_pkg::BRC_OFF);

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          pri_r[g] <= brc_pkg::CODE_RST;
          alt_r[g] <= brc_pkg::CODE_RST;
        end else if (clk_en && reg_wr) begin
          if (reg_addr == brc_pkg::ADDR_PRI0 + 4'(g)) pri_r[g] <= reg_wdata;
          if (reg_addr == brc_pkg::ADDR_ALT0 + 4'(g)) alt_r[g] <= reg_wdata;
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          st_r[g] <= brc_pkg::BRC_OFF;
          ss_cnt_r[g] <= '0;
        end else if (clk_en) begin
          case (st_r[g])
            brc_pkg::BRC_OFF: begin
              if (run_en[g]) begin
                st_r[g] <= brc_pkg::BRC_RAMP;
                ss_cnt_r[g] <= ss_len;
              end
            end
            brc_pkg::BRC_RAMP: begin
              if (!run_en[g]) begin
                st_r[g] <= brc_pkg::BRC_OFF;
              end else if (ss_cnt_r[g] <= CW'(1)) begin
                st_r[g] <= brc_pkg::BRC_RUN;
              end else begin
                ss_cnt_r[g] <= ss_cnt_r[g] - CW'(1);
              end
            end
            brc_pkg::BRC_RUN: begin
              if (!run_en[g]) begin
                st_r[g] <= brc_pkg::BRC_OFF;
              end else if (fault_restart[g]) begin
                st_r[g] <= brc_pkg::BRC_RAMP;
                ss_cnt_r[g] <= ss_len;
              end
            end
            default: st_r[g] <= brc_pkg::BRC_OFF;
          endcase
        end
      end

      // Target code steps one LSB per slew period; during soft-start it follows directly.
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          code_r[g] <= brc_pkg::CODE_RST;
          slew_cnt_r[g] <= '0;
        end else if (clk_en) begin
          if (st_r[g] != brc_pkg::BRC_RUN) begin
            code_r[g] <= tgt;
            slew_cnt_r[g] <= '0;
          end else if (moving[g]) begin
            if (slew_cnt_r[g] >= CW'(SLEW_CYCLES - 1)) begin
              slew_cnt_r[g] <= '0;
              code_r[g] <= (code_r[g] < tgt) ? code_r[g] + 8'h01 : code_r[g] - 8'h01;
            end else begin
              slew_cnt_r[g] <= slew_cnt_r[g] + CW'(1);
            end
          end else begin
            slew_cnt_r[g] <= '0;
          end
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          output_voltage_code[g*8 +: 8] <= 8'h00;
          buck_mode[g*2 +: 2] <= brc_pkg::BRC_MODE_PWM;
          high_side_hold[g] <= 1'b0;
          discharge_en[g] <= 1'b1;
          soft_start_active[g] <= 1'b0;
          buck_enabled[g] <= 1'b0;
        end else if (clk_en) begin
          output_voltage_code[g*8 +: 8] <= code_r[g];
          if (force_eff || any_moving || !light_load[g]) begin
            buck_mode[g*2 +: 2] <= brc_pkg::BRC_MODE_PWM;
          end else if (lpq_ok) begin
            buck_mode[g*2 +: 2] <= brc_pkg::BRC_MODE_LPQ;
          end else begin
            buck_mode[g*2 +: 2] <= brc_pkg::BRC_MODE_SAVE;
          end
          high_side_hold[g] <= full_duty[g] && (st_r[g] == brc_pkg::BRC_RUN);
          discharge_en[g] <= (st_r[g] == brc_pkg::BRC_OFF);
          soft_start_active[g] <= (st_r[g] == brc_pkg::BRC_RAMP);
          buck_enabled[g] <= (st_r[g] != brc_pkg::BRC_OFF);
        end
      end
    end
  endgenerate

  // Status bits 0..2 are overvoltage per buck, bits 4..6 mark soft-start completion.
  always_comb begin
    status_set = 8'h00;
    for (int i = 0; i < NUM_BUCK; i++) begin
      status_set[i] = ov_evt[i];
      status_set[i+4] = (st_r[i] == brc_pkg::BRC_RAMP) && (ss_cnt_r[i] <= CW'(1)) && run_en[i];
    end
  end

  // A set in the same cycle as a write-one clear wins, so no event is lost.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == brc_pkg::ADDR_STATUS) begin
        status_r <= (status_r & ~reg_wdata) | status_set;
      end else begin
        status_r <= status_r | status_set;
      end
    end
  end

  assign irq = |(status_r & mask_r);

  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      brc_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
      brc_pkg::ADDR_ON: rdata_nxt[NUM_BUCK-1:0] = on_r;
      brc_pkg::ADDR_STATUS: rdata_nxt = status_r;
      brc_pkg::ADDR_MASK: rdata_nxt = mask_r;
      brc_pkg::ADDR_LINK: rdata_nxt[NUM_BUCK-1:0] = link_r;
      brc_pkg::ADDR_STATE: rdata_nxt[NUM_BUCK-1:0] = buck_enabled;
      default: begin
        for (int i = 0; i < NUM_BUCK; i++) begin
          if (reg_addr == brc_pkg::ADDR_PRI0 + 4'(i)) rdata_nxt = pri_r[i];
          if (reg_addr == brc_pkg::ADDR_ALT0 + 4'(i)) rdata_nxt = alt_r[i];
          if (i < 2 && reg_addr == brc_pkg::ADDR_CODE0 + 4'(i)) rdata_nxt = code_r[i];
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
    end
  end
endmodule

/* brc_chk.sv */
`timescale 1ns/100ps
module brc_chk #(
  parameter int NUM_BUCK = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [NUM_BUCK-1:0] light_load,
  input wire logic [NUM_BUCK-1:0] full_duty,
  input wire logic [NUM_BUCK*8-1:0] output_voltage_code,
  input wire logic [NUM_BUCK*2-1:0] buck_mode,
  input wire logic [NUM_BUCK-1:0] soft_start_active,
  input wire logic [NUM_BUCK-1:0] high_side_hold,
  input wire logic [NUM_BUCK-1:0] discharge_en,
  input wire logic [NUM_BUCK-1:0] buck_enabled,
  input wire logic fsw_high_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_discharge_when_on: assert property ((discharge_en & buck_enabled) == '0)
    else $error("discharge active on a running converter");
  chk_light_mode_only: assert property (buck_mode[1:0] != 2'b00 |-> $past(light_load[0]))
    else $error("light-load mode without light load");
  chk_hold_full_duty: assert property (high_side_hold[0] |-> $past(full_duty[0]))
    else $error("high side held without full duty demand");
  chk_fsw_write: assert property (reg_wr && reg_addr == brc_pkg::ADDR_CTRL |=>
    fsw_high_select == $past(reg_wdata[brc_pkg::CTRL_FSW]))
    else $error("frequency select does not follow write");
  chk_ramp_length: assert property ($rose(soft_start_active[0]) |->
    soft_start_active[0] [*6] ##[1:24] !soft_start_active[0])
    else $error("soft-start ramp length out of range");
  chk_ramp_on_start: assert property ($fell(discharge_en[0]) |-> ##[0:2] soft_start_active[0])
    else $error("converter started without soft-start");
  chk_code_slew: assert property (buck_enabled[0] && !soft_start_active[0] &&
    $past(buck_enabled[0]) && !$past(soft_start_active[0]) |->
    (output_voltage_code[7:0] - $past(output_voltage_code[7:0])) inside {8'h00, 8'h01, 8'hff})
    else $error("setpoint code stepped by more than one");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data present without read");
endmodule

/* brc_host.sv */
`timescale 1ns/100ps
module brc_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // An idle cycle follows each strobe, so one task never lands twice on an edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule

/* test_buck_regulator_control.sv */
`timescale 1ns/100ps
module test_buck_regulator_control;
  localparam int SSS = 20;
  localparam int SSF = 8;
  localparam int SLW = 2;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic reg_wr, reg_rd, fsw_high_select, irq;
  logic [2:0] fault_restart = 3'h0, light_load = 3'h0, full_duty = 3'h0;
  logic [23:0] output_voltage_code;
  logic [5:0] buck_mode;
  logic [2:0] soft_start_active, high_side_hold, discharge_en, buck_enabled;
  logic [7:0] ctl [4] = '{8'h04, 8'h0c, 8'h08, 8'h06};
  logic [1:0] mexp [4] = '{2'b01, 2'b01, 2'b10, 2'b00};
  int failures = 0, checks_done = 0, n;
  brc_host i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  brc_top #(.NUM_BUCK(3), .SS_SLOW_CYCLES(SSS), .SS_FAST_CYCLES(SSF), .SLEW_CYCLES(SLW)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fault_restart(fault_restart),
    .light_load(light_load), .full_duty(full_duty), .output_voltage_code(output_voltage_code),
    .buck_mode(buck_mode), .soft_start_active(soft_start_active),
    .high_side_hold(high_side_hold), .discharge_en(discharge_en),
    .buck_enabled(buck_enabled), .fsw_high_select(fsw_high_select), .irq(irq));
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    i_host.rd(a, rv);
    chk8(nm, e, rv);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Counts edges until the ramp flag reaches v; a stuck flag ends the run.
  task automatic wait_ss(input int b, input logic v, input int lim);
    n = 0;
    while (soft_start_active[b] !== v) begin
      tick(1);
      n++;
      if (n > lim) begin
        $display("[ERR] soft-start flag exp %b got %b", v, soft_start_active[b]);
        failures++;
        final_report();
      end
    end
  endtask
  task automatic t_reset();
    chk8("discharge", 8'h07, {5'h0, discharge_en});
    rchk("ctrl", brc_pkg::ADDR_CTRL, brc_pkg::CTRL_RST);
    rchk("unmapped", 4'hf, 8'h00);
    rchk("state", brc_pkg::ADDR_STATE, 8'h00);
  endtask
  task automatic t_enable();
    i_host.wr(brc_pkg::ADDR_PRI0, 8'h10);
    i_host.wr(brc_pkg::ADDR_ON, 8'h01);
    wait_ss(0, 1'b1, 8);
    wait_ss(0, 1'b0, SSS + 8);
    chk8("slow ramp", 8'h01, {7'h0, n >= SSS - 2 && n <= SSS + 2});
    chk8("enabled", 8'h01, {5'h0, buck_enabled});
    chk8("discharge", 8'h06, {5'h0, discharge_en});
    chk8("code", 8'h10, output_voltage_code[7:0]);
    rchk("code read", brc_pkg::ADDR_CODE0, 8'h10);
    rchk("status", brc_pkg::ADDR_STATUS, 8'h10);
  endtask
  task automatic t_mode();
    @(posedge clk);
    light_load <= 3'h1;
    full_duty <= 3'h1;
    for (int i = 0; i < 4; i++) begin
      i_host.wr(brc_pkg::ADDR_CTRL, ctl[i]);
      tick(3);
      chk8("mode", {6'h0, mexp[i]}, {6'h0, buck_mode[1:0]});
    end
    chk8("hold", 8'h01, {7'h0, high_side_hold[0]});
    i_host.wr(brc_pkg::ADDR_CTRL, 8'h24);
    tick(1);
    chk8("fsw", 8'h01, {7'h0, fsw_high_select});
    i_host.wr(brc_pkg::ADDR_CTRL, 8'h04);
    full_duty <= 3'h0;
  endtask
  task automatic t_scale();
    i_host.wr(brc_pkg::ADDR_ALT0, 8'h0c);
    i_host.wr(brc_pkg::ADDR_CTRL, 8'h14);
    rchk("force in move", brc_pkg::ADDR_CTRL, 8'h16);
    tick(4 * SLW + 8);
    chk8("alt code", 8'h0c, output_voltage_code[7:0]);
    rchk("force back", brc_pkg::ADDR_CTRL, 8'h14);
  endtask
  task automatic t_irq();
    i_host.wr(brc_pkg::ADDR_STATUS, 8'hff);
    i_host.wr(brc_pkg::ADDR_MASK, 8'h01);
    i_host.wr(brc_pkg::ADDR_ALT0, 8'h30);
    tick(3);
    chk8("irq", 8'h01, {7'h0, irq});
    i_host.wr(brc_pkg::ADDR_MASK, 8'h00);
    tick(1);
    chk8("irq masked", 8'h00, {7'h0, irq});
    i_host.wr(brc_pkg::ADDR_CTRL, 8'h04);
    i_host.wr(brc_pkg::ADDR_ALT0, 8'h0c);
    i_host.wr(brc_pkg::ADDR_STATUS, 8'hff);
  endtask
  // A write while the clock enable is low must leave the register untouched.
  task automatic t_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    i_host.wr(brc_pkg::ADDR_MASK, 8'h01);
    @(posedge clk);
    clk_en <= 1'b1;
    rchk("frozen mask", brc_pkg::ADDR_MASK, 8'h00);
  endtask
  task automatic t_off();
    i_host.wr(brc_pkg::ADDR_CTRL, 8'h05);
    i_host.wr(brc_pkg::ADDR_ON, 8'h03);
    wait_ss(1, 1'b1, 8);
    wait_ss(1, 1'b0, SSF + 8);
    chk8("fast ramp", 8'h01, {7'h0, n >= SSF - 2 && n <= SSF + 2});
    @(posedge clk);
    fault_restart <= 3'h1;
    @(posedge clk);
    fault_restart <= 3'h0;
    wait_ss(0, 1'b1, 4);
    wait_ss(0, 1'b0, SSF + 8);
    i_host.wr(brc_pkg::ADDR_PRI0 + 4'h2, 8'h20);
    i_host.wr(brc_pkg::ADDR_LINK, 8'h04);
    i_host.wr(brc_pkg::ADDR_ON, 8'h07);
    wait_ss(2, 1'b1, 8);
    wait_ss(2, 1'b0, SSF + 8);
    chk8("code2", 8'h20, output_voltage_code[23:16]);
    i_host.wr(brc_pkg::ADDR_ON, 8'h05);
    tick(3);
    chk8("follower off", 8'h01, {5'h0, buck_enabled});
    i_host.wr(brc_pkg::ADDR_ON, 8'h00);
    tick(3);
    chk8("off", 8'h00, {5'h0, buck_enabled});
    chk8("discharge", 8'h07, {5'h0, discharge_en});
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    t_reset();
    t_enable();
    t_mode();
    t_scale();
    t_irq();
    t_freeze();
    t_off();
    final_report();
  end
endmodule
bind brc_top brc_chk #(.NUM_BUCK(NUM_BUCK)) u_chk (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .light_load(light_load), .full_duty(full_duty),
  .output_voltage_code(output_voltage_code), .buck_mode(buck_mode),
  .soft_start_active(soft_start_active), .high_side_hold(high_side_hold),
  .discharge_en(discharge_en), .buck_enabled(buck_enabled), .fsw_high_select(fsw_high_select));
